// >>> verilog/lca_l2_config_access.sv
/*
  L2 configuration access command block: Wishbone register slave holding the
  command control, launch, progress, address, ECC and chunk data registers,
  and a sequencer that issues one command to the L2 array per launch of a known code.
  Assumes one 200 MHz clock, synchronous active-high reset, and an L2 array
  that answers a held request with a one-cycle acknowledge.
*/
// Design decision made here: register access over Wishbone.
// What this block and its software do
// R01 - Control register bits 4:0 hold the L2 command issued on launch.
// R02 - Lookup completion loads hit bit 16, state 13:12, way 11:10.
// R03 - Coherence states coded Modified 11, Exclusive 10, Shared 01, Invalid 00.
// R04 - Way fields binary, way 0 is 00 through way 3 is 11.
// R05 - 01100 data read with LRU, 01110 tag and data read, 01111 inquire.
// R06 - 00010 reads the L2 control register, 00011 writes it.
// R07 - Prefix 010, 111, 100 plus state are tag writes with read, write, none.
// R08 - Writing the launch register starts the access; software writes zero.
// R09 - Progress bit 0 stays one while a launched command is in flight.
// R10 - Software loads the line address first; its low three bits are zero.
// R11 - Four 64-bit chunk registers supply write data and capture read data.
// R12 - Software waits for progress zero before reading results or relaunching.
// R13 - Progress clears only after response fields and read data are stored.
module lca_l2_config_access (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [15:0]  wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  output logic              l2_req_o,
  output logic      [4:0]   l2_cmd_o,
  output logic      [1:0]   l2_way_o,
  output logic      [1:0]   l2_state_o,
  output logic      [35:3]  l2_addr_o,
  output logic              l2_tag_wr_o,
  output logic              l2_data_wr_o,
  output logic              l2_data_rd_o,
  output logic              l2_user_ecc_o,
  output logic      [255:0] l2_wdata_o,
  output logic      [7:0]   l2_wecc_o,
  input  wire logic         l2_ack_i,
  input  wire logic         l2_hit_i,
  input  wire logic [1:0]   l2_state_i,
  input  wire logic [1:0]   l2_way_i,
  input  wire logic [255:0] l2_rdata_i,
  input  wire logic [7:0]   l2_recc_i
);
  import lca_pkg::*;

  logic [63:0] ctl_q;
  logic [63:0] chunk_q [NUM_CHUNKS];
  logic [32:0] addr_q;
  logic [7:0]  ecc_q;
  logic [4:0]  cmd_q;
  lca_fsm_t    fsm_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic [13:0] idx;
  logic [13:0] base;
  logic        hi;
  logic        acc;
  logic        wr_en;
  logic        launch_we;
  logic        busy;
  logic        done;
  logic [4:0]  dec;
  logic [4:0]  dec_ctl;
  logic [31:0] addr_lo;

  function automatic logic [31:0] wr32(input logic [31:0] old, input logic [31:0] dat,
                                      input logic [3:0] sel);
    logic [31:0] m;
    m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    return (old & ~m) | (dat & m);
  endfunction : wr32

  assign idx       = wb_adr_i[15:2];
  assign hi        = idx[IDX_HI_BIT];
  assign base      = {1'b0, idx[12:0]};
  assign acc       = wb_cyc_i & wb_stb_i;
  // Writes land on the edge at which the master sees ack
  assign wr_en     = acc & wb_we_i & ack_q;
  assign launch_we = wr_en & !hi & (base == IDX_LAUNCH);
  assign busy      = (fsm_q != ST_IDLE);
  assign done      = (fsm_q == ST_ISSUE) & l2_ack_i;
  assign dec       = lca_decode(cmd_q);
  // Decode of the programmed command, looked at when a launch is accepted
  assign dec_ctl   = lca_decode(ctl_q[4:0]);
  // Low address word as it would read after this write, before dropping bits 2:0
  assign addr_lo   = wr32({addr_q[28:0], 3'b000}, wb_dat_i, wb_sel_i);

  // Bus answer: one wait state, then ack for exactly one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q  <= acc & !ack_q;
      rdat_q <= rdat_d;
    end
  end

  always_comb begin
    rdat_d = 32'h0;
    for (int i = 0; i < NUM_CHUNKS; i++) begin
      if (base == IDX_CHUNK0 + 14'(i)) begin
        rdat_d = hi ? chunk_q[i][63:32] : chunk_q[i][31:0];
      end
    end
    if (base == IDX_ADDR) begin
      rdat_d = hi ? {28'h0, addr_q[32:29]} : {addr_q[28:0], 3'b000};
    end else if (!hi && base == IDX_ECC) begin
      rdat_d = {24'h0, ecc_q};
    end else if (!hi && base == IDX_CTL) begin
      rdat_d = ctl_q[31:0];
    end else if (!hi && base == IDX_PROGRESS) begin
      rdat_d = {31'h0, busy};                                         // [R09]
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // Control register: software fields by mask, response fields by hardware
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= CTL_RST;
    end else begin
      if (wr_en && !hi && base == IDX_CTL) begin
        ctl_q[31:0] <= (ctl_q[31:0] & ~CTL_WR_MASK[31:0])
                       | (wr32(ctl_q[31:0], wb_dat_i, wb_sel_i) & CTL_WR_MASK[31:0]);
      end
      if (done && dec[DEC_LOOKUP]) begin                                // [R02]
        ctl_q[CTL_HIT_BIT]                             <= l2_hit_i;
        ctl_q[CTL_STATE_FROM_LSB+1:CTL_STATE_FROM_LSB] <= l2_state_i; // [R03]
        ctl_q[CTL_WAY_FROM_LSB+1:CTL_WAY_FROM_LSB]     <= l2_way_i;   // [R04]
      end
    end
  end

  // Chunk data and ECC staging; read data captured on completion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_CHUNKS; i++) begin
        chunk_q[i] <= CHUNK_RST;
      end
      ecc_q <= ECC_RST;
    end else if (done && dec[DEC_DATA_RD]) begin
      for (int i = 0; i < NUM_CHUNKS; i++) begin
        chunk_q[i] <= l2_rdata_i[64*i +: 64];                          // [R11]
      end
      ecc_q <= l2_recc_i;
    end else if (wr_en) begin
      for (int i = 0; i < NUM_CHUNKS; i++) begin
        if (base == IDX_CHUNK0 + 14'(i)) begin
          if (hi) begin
            chunk_q[i][63:32] <= wr32(chunk_q[i][63:32], wb_dat_i, wb_sel_i);
          end else begin
            chunk_q[i][31:0] <= wr32(chunk_q[i][31:0], wb_dat_i, wb_sel_i);
          end
        end
      end
      if (!hi && base == IDX_ECC && wb_sel_i[0]) begin
        ecc_q <= wb_dat_i[7:0];
      end
    end
  end

  // Line address staging; low three bits are not stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      addr_q <= ADDR_RST;
    end else if (wr_en && base == IDX_ADDR) begin
      if (hi) begin
        if (wb_sel_i[0]) begin
          addr_q[32:29] <= wb_dat_i[3:0];
        end
      end else begin
        addr_q[28:0] <= addr_lo[31:3];
      end
    end
  end

  // Sequencer: launch latches the command, busy covers issue and write-back
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fsm_q <= ST_IDLE;
      cmd_q <= 5'h0;
    end else begin
      case (fsm_q)
        ST_IDLE: begin
          if (launch_we) begin                                          // [R08]
            cmd_q <= ctl_q[4:0];                                        // [R01]
            // Unknown codes skip the array but still pulse busy
            fsm_q <= dec_ctl[DEC_KNOWN] ? ST_ISSUE : ST_LATCH;
          end
        end
        ST_ISSUE: begin
          if (l2_ack_i) begin
            fsm_q <= ST_LATCH;                                          // [R09]
          end
        end
        ST_LATCH: begin
          fsm_q <= ST_IDLE;                                             // [R13]
        end
        default: begin
          fsm_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Request to the array, held until acknowledged
  assign l2_req_o      = (fsm_q == ST_ISSUE);
  assign l2_cmd_o      = cmd_q;
  assign l2_tag_wr_o   = l2_req_o & dec[DEC_TAG_WR];                     // [R07]
  assign l2_data_wr_o  = l2_req_o & dec[DEC_DATA_WR];                    // [R06]
  assign l2_data_rd_o  = l2_req_o & dec[DEC_DATA_RD];                    // [R05]
  assign l2_way_o      = ctl_q[CTL_WAY_TO_LSB+1:CTL_WAY_TO_LSB];         // [R04]
  assign l2_state_o    = ctl_q[CTL_STATE_TO_LSB+1:CTL_STATE_TO_LSB];     // [R03]
  assign l2_user_ecc_o = ctl_q[CTL_USER_ECC_BIT];
  assign l2_addr_o     = addr_q;
  assign l2_wecc_o     = ecc_q;
  always_comb begin
    for (int i = 0; i < NUM_CHUNKS; i++) begin
      l2_wdata_o[64*i +: 64] = chunk_q[i];                               // [R11]
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_launch;
    launch_we && fsm_q == ST_IDLE;
  endsequence
  sequence s_complete;
    l2_req_o && l2_ack_i;
  endsequence
  sequence s_known_launch;
    launch_we && fsm_q == ST_IDLE && dec_ctl[DEC_KNOWN];
  endsequence
  sequence s_unknown_launch;
    launch_we && fsm_q == ST_IDLE && !dec_ctl[DEC_KNOWN];
  endsequence

  chk_launch_start: assert property (s_launch |=> busy && cmd_q == $past(ctl_q[4:0])) // [R08]
    else $error("launch did not start a command");
  chk_cmd_drive: assert property (l2_req_o |-> l2_cmd_o == cmd_q && dec[DEC_KNOWN]) // [R01]
    else $error("command on array port differs from latched command");
  chk_busy_hold: assert property (fsm_q == ST_ISSUE && !l2_ack_i |=> busy && l2_req_o) // [R09]
    else $error("busy or request dropped before acknowledge");
  chk_busy_release: assert property (s_complete |=> busy ##1 !busy) // [R13]
    else $error("busy did not clear one cycle after write-back");
  chk_resp_load: assert property ((s_complete and dec[DEC_LOOKUP]) |=> // [R02]
      ctl_q[CTL_HIT_BIT] == $past(l2_hit_i)
      && ctl_q[CTL_STATE_FROM_LSB+1:CTL_STATE_FROM_LSB] == $past(l2_state_i)
      && ctl_q[CTL_WAY_FROM_LSB+1:CTL_WAY_FROM_LSB] == $past(l2_way_i))
    else $error("lookup response not loaded");
  chk_data_capture: assert property ((s_complete and dec[DEC_DATA_RD]) |=> // [R11]
      chunk_q[0] == $past(l2_rdata_i[63:0]) && chunk_q[3] == $past(l2_rdata_i[255:192]))
    else $error("read data not captured");
  chk_lookup_decode: assert property (l2_req_o && cmd_q == CMD_TAG_INQUIRE |-> // [R05]
      !l2_data_rd_o && !l2_tag_wr_o && !l2_data_wr_o)
    else $error("inquire decoded as data or tag access");
  chk_lru_decode: assert property (l2_req_o && cmd_q == CMD_DATA_READ_LRU_UPDATE |-> // [R05]
      l2_data_rd_o && !l2_tag_wr_o)
    else $error("data read with LRU update misdecoded");
  chk_cfg_decode: assert property (l2_req_o && cmd_q == CMD_L2_CONFIG_WRITE |-> // [R06]
      l2_data_wr_o && !l2_data_rd_o && !l2_tag_wr_o)
    else $error("config write misdecoded");
  chk_tagwr_decode: assert property (l2_req_o && cmd_q[4:2] == PFX_TAG_WRITE_DATA_WRITE |-> // [R07]
      l2_tag_wr_o && l2_data_wr_o && !l2_data_rd_o)
    else $error("tag write with data write misdecoded");
  chk_way_state_out: assert property (s_launch |=> // [R04]
      l2_way_o == $past(ctl_q[9:8]) && l2_state_o == $past(ctl_q[6:5]))
    else $error("way or state to array not from control register");
  chk_busy_read: assert property (acc && !wb_we_i && !ack_q && !hi && base == IDX_PROGRESS // [R09]
      |=> wb_ack_o && wb_dat_o[0] == $past(busy))
    else $error("progress read does not show busy");
  chk_wb_ack: assert property (acc && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single cycle after one wait state");
  chk_req_start: assert property (s_known_launch |=> l2_req_o && busy) // [R08]
    else $error("known command did not raise the array request");
  chk_unknown_skip: assert property (s_unknown_launch |=> !l2_req_o && busy ##1 !busy) // [R09]
    else $error("unknown command reached the array or held busy too long");
  chk_tag_read_decode: assert property (l2_req_o && cmd_q == CMD_TAG_READ_DATA_READ |-> // [R05]
      l2_data_rd_o && !l2_tag_wr_o && !l2_data_wr_o)
    else $error("tag read with data read misdecoded");
  chk_cfg_read_decode: assert property (l2_req_o && cmd_q == CMD_L2_CONFIG_READ |-> // [R06]
      l2_data_rd_o && !l2_data_wr_o && !l2_tag_wr_o)
    else $error("config read misdecoded");
  chk_tagrd_decode: assert property (l2_req_o && cmd_q[4:2] == PFX_TAG_WRITE_DATA_READ // [R07]
      |-> l2_tag_wr_o && l2_data_rd_o && !l2_data_wr_o)
    else $error("tag write with data read misdecoded");
  chk_tagonly_decode: assert property (l2_req_o && cmd_q[4:2] == PFX_TAG_ONLY_WRITE |-> // [R07]
      l2_tag_wr_o && !l2_data_wr_o && !l2_data_rd_o)
    else $error("tag only write misdecoded");

endmodule : lca_l2_config_access

// >>> verilog/lca_pkg.sv
/*
  Constants, command codes and decode helper for the L2 configuration access
  command block. Assumes a 32-bit classic Wishbone register bus with byte
  addresses; a register index is the byte address divided by four.
*/
package lca_pkg;

  // Register indices (byte address = 4 * index)
  localparam logic [13:0] IDX_CHUNK0   = 14'h0088;
  localparam logic [13:0] IDX_ADDR     = 14'h0116;
  localparam logic [13:0] IDX_ECC      = 14'h0118;
  localparam logic [13:0] IDX_CTL      = 14'h0119;
  localparam logic [13:0] IDX_LAUNCH   = 14'h011a;
  localparam logic [13:0] IDX_PROGRESS = 14'h011b;
  // Index bit that selects the upper word of a 64-bit register
  localparam int          IDX_HI_BIT   = 13;
  localparam int          NUM_CHUNKS   = 4;

  // Control register field positions
  localparam int CTL_STATE_TO_LSB   = 5;
  localparam int CTL_WAY_TO_LSB     = 8;
  localparam int CTL_WAY_FROM_LSB   = 10;
  localparam int CTL_STATE_FROM_LSB = 12;
  localparam int CTL_HIT_BIT        = 16;
  localparam int CTL_USER_ECC_BIT   = 18;
  localparam int CTL_PROC_DIS_BIT   = 21;
  localparam logic [63:0] CTL_WR_MASK = 64'h0000_0000_0024_037f;

  // Reset values
  localparam logic [63:0] CTL_RST   = 64'h0;
  localparam logic [63:0] CHUNK_RST = 64'h0;
  localparam logic [32:0] ADDR_RST  = 33'h0;
  localparam logic [7:0]  ECC_RST   = 8'h0;

  // Command codes
  localparam logic [4:0] CMD_DATA_READ_LRU_UPDATE = 5'h0c;
  localparam logic [4:0] CMD_TAG_READ_DATA_READ   = 5'h0e;
  localparam logic [4:0] CMD_TAG_INQUIRE          = 5'h0f;
  localparam logic [4:0] CMD_L2_CONFIG_READ       = 5'h02;
  localparam logic [4:0] CMD_L2_CONFIG_WRITE      = 5'h03;
  localparam logic [2:0] PFX_TAG_WRITE_DATA_READ  = 3'h2;
  localparam logic [2:0] PFX_TAG_WRITE_DATA_WRITE = 3'h7;
  localparam logic [2:0] PFX_TAG_ONLY_WRITE       = 3'h4;

  // Coherence state codes
  localparam logic [1:0] MESI_MODIFIED  = 2'h3;
  localparam logic [1:0] MESI_EXCLUSIVE = 2'h2;
  localparam logic [1:0] MESI_SHARED    = 2'h1;
  localparam logic [1:0] MESI_INVALID   = 2'h0;

  // Decode flag positions
  localparam int DEC_TAG_WR  = 0;
  localparam int DEC_DATA_WR = 1;
  localparam int DEC_DATA_RD = 2;
  localparam int DEC_LOOKUP  = 3;
  localparam int DEC_KNOWN   = 4;

  typedef enum logic [1:0] {ST_IDLE, ST_ISSUE, ST_LATCH} lca_fsm_t;

  function automatic logic [4:0] lca_decode(input logic [4:0] cmd);
    logic [4:0] f;
    logic       is_rd_lru, is_tag_rd, is_inq, is_cfg_rd, is_cfg_wr;
    logic       is_tagw_rd, is_tagw_wr, is_tagw_only;
    f            = 5'h0;
    is_rd_lru    = (cmd == CMD_DATA_READ_LRU_UPDATE);
    is_tag_rd    = (cmd == CMD_TAG_READ_DATA_READ);
    is_inq       = (cmd == CMD_TAG_INQUIRE);
    is_cfg_rd    = (cmd == CMD_L2_CONFIG_READ);
    is_cfg_wr    = (cmd == CMD_L2_CONFIG_WRITE);
    is_tagw_rd   = (cmd[4:2] == PFX_TAG_WRITE_DATA_READ);
    is_tagw_wr   = (cmd[4:2] == PFX_TAG_WRITE_DATA_WRITE);
    is_tagw_only = (cmd[4:2] == PFX_TAG_ONLY_WRITE);
    f[DEC_TAG_WR]  = is_tagw_rd | is_tagw_wr | is_tagw_only;
    f[DEC_DATA_WR] = is_tagw_wr | is_cfg_wr;
    f[DEC_DATA_RD] = is_rd_lru | is_tag_rd | is_tagw_rd | is_cfg_rd;
    f[DEC_LOOKUP]  = is_rd_lru | is_tag_rd | is_inq;
    f[DEC_KNOWN]   = is_rd_lru | is_tag_rd | is_inq | is_cfg_rd | is_cfg_wr
                     | is_tagw_rd | is_tagw_wr | is_tagw_only;
    return f;
  endfunction : lca_decode

endpackage : lca_pkg

// >>> bench/lca_l2_model.sv
/*
  Behavioural L2 array for the configuration access block.
  Assumes a held level request; answers with a one-cycle acknowledge after
  dly_i cycles and derives its lookup response and read data from the address.
*/
module lca_l2_model (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         req_i,
  input  wire logic [35:3]  addr_i,
  input  wire logic [7:0]   dly_i,
  output logic              ack_o,
  output logic              hit_o,
  output logic      [1:0]   state_o,
  output logic      [1:0]   way_o,
  output logic      [255:0] rdata_o,
  output logic      [7:0]   recc_o
);
  logic [7:0]   cnt_q;
  logic [255:0] data;

  always_ff @(posedge clk_i) begin
    if (rst_i || !req_i) begin
      cnt_q <= 8'h00;
    end else if (cnt_q != 8'hff) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // One pulse per request, prompt or slow as the bench asks
  assign ack_o = req_i && (cnt_q == dly_i);

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      data[64*i+:64] = {32'(i), addr_i[34:3]};
    end
  end

  // Outside the answer the lines carry the inverse, never the real value
  assign hit_o   = ack_o ? addr_i[7] : ~addr_i[7];
  assign state_o = ack_o ? addr_i[6:5] : ~addr_i[6:5];
  assign way_o   = ack_o ? addr_i[4:3] : ~addr_i[4:3];
  assign rdata_o = ack_o ? data : ~data;
  assign recc_o  = ack_o ? addr_i[10:3] : ~addr_i[10:3];
endmodule : lca_l2_model

// >>> bench/tb.sv
/*
  Self-checking bench for the L2 configuration access block.
  Assumes the block's Wishbone map and the behavioural L2 array model.
*/
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lca_pkg::*;
  typedef struct {logic [31:0] v; bit c;} lca_rd_t;
  logic         clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [15:0]  wb_adr_i;
  logic [3:0]   wb_sel_i;
  logic [31:0]  wb_dat_i, wb_dat_o, seed;
  logic         l2_req_o, l2_tag_wr_o, l2_data_wr_o, l2_data_rd_o, l2_user_ecc_o;
  logic         l2_ack_i, l2_hit_i;
  logic [4:0]   l2_cmd_o;
  logic [1:0]   l2_way_o, l2_state_o, l2_state_i, l2_way_i;
  logic [35:3]  l2_addr_o;
  logic [255:0] l2_wdata_o, l2_rdata_i;
  logic [7:0]   l2_wecc_o, l2_recc_i, dly;
  int           mismatches, n_tests;
  lca_rd_t      rd_q[$];
  logic [43:0]  l2_q[$];

  lca_l2_config_access i_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .l2_req_o(l2_req_o), .l2_cmd_o(l2_cmd_o),
    .l2_way_o(l2_way_o), .l2_state_o(l2_state_o), .l2_addr_o(l2_addr_o),
    .l2_tag_wr_o(l2_tag_wr_o), .l2_data_wr_o(l2_data_wr_o), .l2_data_rd_o(l2_data_rd_o),
    .l2_user_ecc_o(l2_user_ecc_o), .l2_wdata_o(l2_wdata_o), .l2_wecc_o(l2_wecc_o),
    .l2_ack_i(l2_ack_i), .l2_hit_i(l2_hit_i), .l2_state_i(l2_state_i),
    .l2_way_i(l2_way_i), .l2_rdata_i(l2_rdata_i), .l2_recc_i(l2_recc_i));

  lca_l2_model i_l2 (
    .clk_i(clk_i), .rst_i(rst_i), .req_i(l2_req_o), .addr_i(l2_addr_o), .dly_i(dly),
    .ack_o(l2_ack_i), .hit_o(l2_hit_i), .state_o(l2_state_i), .way_o(l2_way_i),
    .rdata_o(l2_rdata_i), .recc_o(l2_recc_i));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic check(input string nm, input logic [43:0] seen, input logic [43:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int t;
    t = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hf;
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    if (t >= 50) mismatches++;
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task automatic rd(input logic [15:0] a, input logic [31:0] e, input bit c,
                    output logic [31:0] q);
    rd_q.push_back('{e, c});
    wb(1'b0, a, 32'h0, q);
  endtask : rd

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr

  // Results are matched against the oldest note as they appear
  always @(posedge clk_i) begin
    lca_rd_t r;
    logic [43:0] e;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0) begin
      r = rd_q.pop_front();
      if (r.c) check("wb_dat_o", 44'(wb_dat_o), 44'(r.v));
    end
    if (l2_ack_i === 1'b1 && l2_q.size() > 0) begin
      e = l2_q.pop_front();
      check("l2_cmd", {l2_cmd_o, l2_way_o, l2_state_o, l2_tag_wr_o, l2_data_wr_o,
            l2_data_rd_o, l2_wdata_o[95:64]}, e);
      check("l2_addr_ecc", 44'({l2_user_ecc_o, l2_wecc_o, l2_addr_o}),
            44'({e[38], e[7:0], 4'h0, e[31:3]}));
    end else if (l2_req_o === 1'b1 && l2_q.size() == 0)
      check("l2_req_o", 44'(l2_req_o), 44'h0);
  end

  initial begin
    #200us;
    mismatches++;
    complete_run();
  end

  initial begin
    logic [31:0] a, c, q;
    static logic [8:0] tab [8] = '{9'h0c3, 9'h0e3, 9'h0f1, 9'h022,
                                   9'h034, 9'h08a, 9'h1cc, 9'h108};
    logic [4:0]  m;
    logic [1:0]  s, w;
    int          t;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
    wb_adr_i = 16'h0;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    dly = 8'h01;
    seed = 32'haa9bcd6d;
    mismatches = 0;
    n_tests = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(16'h046c, 32'h0, 1, q);
    rd(16'h0464, 32'h0, 1, q);
    wr(16'h0464, 32'hffffffff);
    rd(16'h0464, 32'h0024037f, 1, q);
    rd(16'h0000, 32'h0, 1, q);
    // Unknown command: no request, busy gone by the next read
    wr(16'h0464, 32'h0);
    wr(16'h0468, 32'h0);
    rd(16'h046c, 32'h0, 1, q);
    for (int i = 0; i < 8; i++) begin
      a = xs() & 32'hfffffff8;
      w = 2'(xs());
      s = 2'(i);
      m = tab[i][8:4];
      if (i >= 5) m[1:0] = s;
      c = {13'h0, w[1], 8'h0, w, 1'b0, s, m};
      dly <= i[0] ? 8'h01 : 8'h0c;
      wr(16'h0458, a);
      wr(16'h0224, a);
      wr(16'h0460, a);
      wr(16'h0464, c);
      l2_q.push_back({m, w, s, tab[i][3:1], a});
      wr(16'h0468, 32'h0);
      rd(16'h046c, 32'h1, dly == 8'h0c, q);
      t = 0;
      while (q[0] !== 1'b0 && t < 100) begin
        rd(16'h046c, 32'h0, 0, q);
        t++;
      end
      if (t >= 100) mismatches++;
      if (tab[i][0]) rd(16'h0464, c | {15'h0, a[7], 2'h0, a[6:5], a[4:3], 10'h0}, 1, q);
      if (tab[i][1]) begin
        rd(16'h0220, {3'h0, a[31:3]}, 1, q);
        rd(16'h822c, 32'h3, 1, q);
        rd(16'h0460, {24'h0, a[10:3]}, 1, q);
      end
    end
    complete_run();
  end
endmodule : tb
